// [verilog/scd_divider.v]
// synchronous divide-by-2/4/8 stage set with hold and master clear
// assumes all inputs are synchronous to i_clock; the divided clock is a sampled level
//
// Function
// - clear released while input clock high: outputs advance on next rising edge.
// - clear released while input clock low: outputs advance on second rising edge.
// - hold freezes dividers at first falling input edge after it rises.
// - while frozen every divider bit keeps its value; outputs stay static.
// - hold low unfreezes at next falling edge; counting resumes in phase.
`timescale 1ns/100ps
`include "scd_defs.vh"

module scd_divider (
    input wire i_clock,
    input wire i_rst,
    input wire i_div_clock,
    input wire i_hold,
    input wire i_divider_sync_clear,
    output reg o_half_rate_output,
    output reg o_quarter_rate_output_a,
    output reg o_quarter_rate_output_b,
    output reg o_eighth_rate_output,
    output reg o_divider_frozen
);
    // ------------------------------------------------------------
    // realignment states and reset image
    // ------------------------------------------------------------
    // the clear acts as a level, but what follows its release depends on the
    // input level in the cycle it drops, so the release is kept as a state
    localparam [1:0] ST_RUN = 2'b00;
    localparam [1:0] ST_CLEAR = 2'b01;
    localparam [1:0] ST_SKIP = 2'b10;
    localparam [`SCD_COUNT_WIDTH-1:0] COUNT_RESET = `SCD_COUNT_RESET;

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // one binary counter feeds every stage, so the common edges coincide
    function [`SCD_COUNT_WIDTH-1:0] advance_count;
        input [`SCD_COUNT_WIDTH-1:0] value;
        begin
            advance_count = value + `SCD_COUNT_STEP;
        end
    endfunction

    // a release seen with the input low must swallow the first rise
    function [1:0] release_target;
        input clock_level;
        begin
            if (clock_level) begin
                release_target = ST_RUN;
            end else begin
                release_target = ST_SKIP;
            end
        end
    endfunction

    // a sampled rise moves the count only when nothing blocks it
    function rise_counts;
        input rise;
        input frozen_now;
        input skip_pending;
        begin
            rise_counts = rise & ~frozen_now & ~skip_pending;
        end
    endfunction

    // level of one divider stage for a given counter value
    function stage_level;
        input [`SCD_COUNT_WIDTH-1:0] value;
        input integer pos;
        begin
            stage_level = value[pos];
        end
    endfunction

    // ------------------------------------------------------------
    // divider state
    // ------------------------------------------------------------
    reg [1:0] state;
    reg [1:0] next_state;
    reg frozen;
    reg next_frozen;
    reg [`SCD_COUNT_WIDTH-1:0] count;
    reg [`SCD_COUNT_WIDTH-1:0] next_count;
    wire skip_pending;
    wire count_step;
    wire div_rise;
    wire div_fall;

    // the skip state swallows exactly one sampled rise after a low release
    assign skip_pending = (state == ST_SKIP);
    assign count_step = rise_counts(div_rise, frozen, skip_pending);

    // ------------------------------------------------------------
    // input clock edges
    // ------------------------------------------------------------
    // limitation: each level of i_div_clock must last a full i_clock cycle,
    // otherwise the sampled edge is lost and the stages fall out of step
    scd_edge_detect u_edge (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_level(i_div_clock),
        .o_rise(div_rise),
        .o_fall(div_fall)
    );

    // ------------------------------------------------------------
    // realignment after clear
    // ------------------------------------------------------------
    always @* begin
        next_state = state;
        if (i_divider_sync_clear) begin
            next_state = ST_CLEAR;
        end else begin
            case (state)
                ST_CLEAR: begin
                    next_state = release_target(i_div_clock);
                end
                ST_SKIP: begin
                    // any rise spends the skip, frozen or not
                    if (div_rise) begin
                        next_state = ST_RUN;
                    end else begin
                        next_state = ST_SKIP;
                    end
                end
                ST_RUN: begin
                    next_state = ST_RUN;
                end
                default: begin
                    next_state = ST_RUN;
                end
            endcase
        end
    end

    // i_rst returns to plain counting; only a clear arms the realignment
    always @(posedge i_clock) begin
        if (i_rst) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // hold sampling
    // ------------------------------------------------------------
    always @* begin
        next_frozen = frozen;
        if (i_divider_sync_clear) begin
            next_frozen = 1'b0;
        end else if (div_fall) begin
            // hold is taken only where the input is low, so a change of
            // hold can never cut a count step short
            next_frozen = i_hold;
        end
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            frozen <= 1'b0;
        end else begin
            frozen <= next_frozen;
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    // wraps from 7 to 0, so the eighth-rate stage keeps an even duty
    always @* begin
        next_count = count;
        if (i_divider_sync_clear) begin
            next_count = COUNT_RESET;
        end else if (count_step) begin
            next_count = advance_count(count);
        end
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            count <= COUNT_RESET;
        end else begin
            count <= next_count;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    // the outputs load the next count, not the count, so they show a counted
    // rise in the same cycle as the counter and need no extra stage
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_half_rate_output <= stage_level(COUNT_RESET, `SCD_HALF_BIT);
            o_quarter_rate_output_a <= stage_level(COUNT_RESET, `SCD_QUARTER_BIT);
            o_quarter_rate_output_b <= stage_level(COUNT_RESET, `SCD_QUARTER_BIT);
            o_eighth_rate_output <= stage_level(COUNT_RESET, `SCD_EIGHTH_BIT);
        end else begin
            o_half_rate_output <= stage_level(next_count, `SCD_HALF_BIT);
            o_quarter_rate_output_a <= stage_level(next_count, `SCD_QUARTER_BIT);
            // second quarter-rate copy, so two loads see the same edge
            o_quarter_rate_output_b <= stage_level(next_count, `SCD_QUARTER_BIT);
            o_eighth_rate_output <= stage_level(next_count, `SCD_EIGHTH_BIT);
        end
    end

    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------
    // copy of the freeze flag, loaded from its next value like the stages
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_divider_frozen <= 1'b0;
        end else begin
            o_divider_frozen <= next_frozen;
        end
    end
endmodule // scd_divider

// [verilog/scd_defs.vh]
// constants for the synchronous clock divider: counter layout and reset values
// assumes inclusion by bare name from the divider design files
`ifndef SCD_DEFS_VH
`define SCD_DEFS_VH

`define SCD_COUNT_WIDTH 3
`define SCD_COUNT_RESET 3'h0
`define SCD_HALF_BIT 0
`define SCD_QUARTER_BIT 1
`define SCD_EIGHTH_BIT 2
`define SCD_COUNT_STEP 3'h1

`endif

// [verilog/scd_edge_detect.v]
// edge detector for the sampled divider input clock
// assumes i_level is already synchronous to i_clock
`timescale 1ns/100ps

module scd_edge_detect (
    input wire i_clock,
    input wire i_rst,
    input wire i_level,
    output wire o_rise,
    output wire o_fall
);
    reg prev_level;

    always @(posedge i_clock) begin
        if (i_rst) begin
            prev_level <= 1'b0;
        end else begin
            prev_level <= i_level;
        end
    end

    assign o_rise = i_level & ~prev_level;
    assign o_fall = ~i_level & prev_level;
endmodule // scd_edge_detect

// [tb/scd_chk.sv]
// checker on the divider ports; one clock, bound to each scd_divider
// assumes every input changes just after the rising edge of i_clock
`timescale 1ns/100ps
module scd_chk(input wire i_clock, i_rst, i_div_clock, i_hold, i_divider_sync_clear,
    o_half_rate_output, o_quarter_rate_output_a, o_quarter_rate_output_b,
    o_eighth_rate_output, o_divider_frozen);
    reg pd, pc, sk;
    wire k = i_divider_sync_clear;
    wire f = o_divider_frozen;
    wire r = i_div_clock & ~pd;
    wire [2:0] c = {o_eighth_rate_output, o_quarter_rate_output_a, o_half_rate_output};
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // a release while the input is low swallows the next rise
    always @(posedge i_clock) begin
        pd <= i_div_clock;
        pc <= k;
        sk <= !i_rst && !k && ((pc && !i_div_clock) || (sk && !r));
    end
    property p_cnt; r && !f && !k && !sk |=> c == $past(c) + 3'h1; endproperty
    a_cnt: assert property (p_cnt) else $error("rise not counted");
    property p_skp; r && sk && !k |=> $stable(c); endproperty
    a_skp: assert property (p_skp) else $error("rise not swallowed");
    property p_frz; $fell(i_div_clock) && i_hold && !k |=> f; endproperty
    a_frz: assert property (p_frz) else $error("hold not taken");
    property p_hld; f && !k |=> $stable(c); endproperty
    a_hld: assert property (p_hld) else $error("count moved while frozen");
    property p_unf; $fell(i_div_clock) && !i_hold && !k |=> !f; endproperty
    a_unf: assert property (p_unf) else $error("no unfreeze");
    property p_clr; k |=> c == 3'h0 && !f && o_quarter_rate_output_b == c[1]; endproperty
    a_clr: assert property (p_clr) else $error("clear not taken");
    cover property (r && sk);
    cover property (r && f);
    cover property ($fell(k) && i_div_clock);
endmodule // scd_chk
bind scd_divider scd_chk chk(.*);

// [tb/scd_src.sv]
// clock source: i_half cycles high and low, held low while stopped
// assumes i_half stays between 2 and 5, so each level spans two or more clocks
`timescale 1ns/100ps
module scd_src(
    input wire i_clock,
    input wire i_run,
    input wire [2:0] i_half,
    output reg o_div = 1'b0
);
    reg [2:0] n = 3'h1;
    always @(posedge i_clock) begin
        n <= (!i_run || n >= i_half) ? 3'h1 : n + 3'h1;
        o_div <= i_run & (o_div ^ (n >= i_half));
    end
endmodule // scd_src

// [tb/tb_top.sv]
// random hold, clear and rate against a reference; source model drives the input
// assumes the checker binds itself into every scd_divider from its own file
`timescale 1ns/100ps
module tb_top;
    reg c = 0, rst = 1, hd = 0, clr = 0, run = 0, pd = 0, pc = 0, sk = 0;
    reg [2:0] hf = 3'h2;
    reg [3:0] r = 4'h0, n, lc = 4'h0, q[$];
    wire dv, h, qa, qb, e, f;
    integer fails = 0, n_tests = 0, i;
    scd_src src(.i_clock(c), .i_run(run), .i_half(hf), .o_div(dv));
    scd_divider uut(.i_clock(c), .i_rst(rst), .i_div_clock(dv), .i_hold(hd),
        .i_divider_sync_clear(clr), .o_half_rate_output(h), .o_quarter_rate_output_a(qa),
        .o_quarter_rate_output_b(qb), .o_eighth_rate_output(e), .o_divider_frozen(f));
    initial forever #20 c = ~c;
    task results;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input [3:0] x);
        n_tests = n_tests + 1;
        if ({f, e, qa, h} !== x || qb !== qa) begin
            fails = fails + 1;
            $display("wrong value at %0t: got %h expected %h", $time, {f, e, qa, h}, x);
        end
    endtask
    task chk_left(input integer x);
        n_tests = n_tests + 1;
        if (x !== 0) begin
            fails = fails + 1;
            $display("wrong value at %0t: got %h expected %h", $time, x, 0);
        end
    endtask
    always @(posedge c) begin
        n = (rst | clr) ? 4'h0 : r;
        if (!rst && !clr && dv && !pd && !r[3] && !sk) n[2:0] = r[2:0] + 3'h1;
        if (!rst && !clr && !dv && pd) n[3] = hd;
        sk <= !rst && !clr && ((pc && !dv) || (sk && !(dv && !pd)));
        if (n != r) q.push_back(n);
        r <= n;
        pd <= dv;
        pc <= clr;
    end
    always @(posedge c) begin
        #1;
        if (!rst && {f, e, qa, h} !== lc) chk(q.size() ? q.pop_front() : lc);
        lc = {f, e, qa, h};
    end
    initial begin
        void'($urandom(92252));
        repeat (4) @(posedge c);
        #2 rst = 0;
        run = 1;
        for (i = 0; i < 3000; i = i + 1) begin
            @(posedge c);
            #2 hf = 3'h2 + 3'($urandom % 4);
            if ($urandom % 24 == 0) hd = ~hd;
            clr = ($urandom % 120 == 0);
        end
        chk_left(q.size());
        results;
    end
    initial begin
        #200000 fails = fails + 1;
        results;
    end
endmodule // tb_top
